// ### rtl/venc_pkg.sv
package venc_pkg;
  // register offsets, one aligned word each
  localparam logic [11:0] MODE_OFS    = 12'h000;
  localparam logic [11:0] TIMING0_OFS = 12'h004;
  localparam logic [11:0] TIMING1_OFS = 12'h008;
  localparam logic [11:0] PED_OFS     = 12'h00c;
  localparam logic [11:0] SCFREQ_OFS  = 12'h010;
  localparam logic [11:0] STATUS_OFS  = 12'h014;
  localparam logic [11:0] RTCFREQ_OFS = 12'h018;
  // mode register bit positions
  localparam int LUMA_LO_BIT   = 0;
  localparam int LUMA_HI_BIT   = 1;
  localparam int PAL_BIT       = 2;
  localparam int CBAR_BIT      = 3;
  localparam int CHROMA_EN_BIT = 4;
  localparam int BURST_EN_BIT  = 5;
  localparam int PINF_LO_BIT   = 6;
  localparam int PINF_HI_BIT   = 7;
  localparam int PVBI_BIT      = 8;
  localparam int WIDE16_BIT    = 9;
  localparam int SQPIX_BIT     = 10;
  // reset values
  localparam logic [31:0] MODE_RST    = 32'h0000_0030;
  localparam logic [2:0]  TIMING0_RST = 3'h0;
  localparam logic [23:0] TIMING1_RST = 24'h44_92_7e;
  localparam logic [31:0] PED_RST     = 32'h0000_0000;
  localparam logic [31:0] SCFREQ_RST  = 32'h0000_0000;
  // timing mode codes (low three bits of the timing mode register)
  localparam logic [2:0] TMODE_M0_SLAVE  = 3'h0;
  localparam logic [2:0] TMODE_M0_MASTER = 3'h1;
  // line geometry in clocks and lines
  localparam logic [11:0] NTSC_CLKS    = 12'd1716;
  localparam logic [11:0] PAL_CLKS     = 12'd1728;
  localparam logic [11:0] NTSC_SQ_CLKS = 12'd1560;
  localparam logic [11:0] PAL_SQ_CLKS  = 12'd1888;
  localparam logic [11:0] ACTIVE_CLKS  = 12'd1440;
  localparam logic [9:0]  NTSC_LINES   = 10'd525;
  localparam logic [9:0]  PAL_LINES    = 10'd625;
  localparam logic [9:0]  NTSC_F2      = 10'd264;
  localparam logic [9:0]  PAL_F2       = 10'd313;
  localparam logic [9:0]  NTSC_VBI     = 10'd19;
  localparam logic [9:0]  PAL_VBI      = 10'd22;
  localparam logic [9:0]  NTSC_EQ      = 10'd9;
  localparam logic [9:0]  PAL_EQ       = 10'd5;
  localparam logic [9:0]  PED_F1_FIRST = 10'd10;
  localparam logic [9:0]  PED_F2_FIRST = 10'd273;
  localparam logic [9:0]  PED_LINES    = 10'd16;
  // real-time control stream
  localparam int RTC_BITS      = 67;
  localparam int RTC_FREQ_BITS = 22;
  localparam int RTC_BIT_CLKS  = 2;
  localparam logic [7:0] RTC_LAST_CNT = 8'(RTC_BIT_CLKS * RTC_BITS);
  localparam logic [7:0] HOST_LAST_CNT = 8'(RTC_BIT_CLKS * (RTC_BITS + 1) - 1);
  // colour bars: pixels per bar, then {y,cb,cr} from right bar to left bar
  localparam logic [7:0] CBAR_PIX = 8'd90;
  localparam logic [7:0][23:0] CBAR_TABLE = {
    24'h10_80_80, 24'h23_d4_72, 24'h41_64_d4, 24'h54_b8_c6,
    24'h70_48_3a, 24'h83_9c_2c, 24'ha2_2c_8e, 24'heb_80_80};
  localparam logic [7:0] BLACK_Y  = 8'h10;
  localparam logic [7:0] ZERO_C   = 8'h80;
  localparam logic [7:0] CODE_FF  = 8'hff;
  localparam logic [7:0] CODE_00  = 8'h00;

  typedef enum logic [1:0] {RESP_LOWPASS, RESP_NOTCH, RESP_EXTENDED} luma_resp_type;
endpackage

// ### rtl/venc_link_if.sv
`timescale 1ns/100ps
`default_nettype none
// bit 0 horizontal sync, bit 1 blank, bit 2 field/vertical sync
interface venc_link_if (
  input wire logic mclk
);
  logic [7:0] pixel_low_byte;
  logic [7:0] pixel_high_byte;
  logic       subcarrier_sync_input;
  logic [2:0] dev_tim_o;
  logic [2:0] dev_tim_oe_n;
  logic [2:0] host_tim_o;
  logic [2:0] host_tim_oe_n;
  wire logic [2:0] tim;

  // undriven timing pins float high through the board pull-up
  for (genvar i = 0; i < 3; i++) begin : g_pin
    assign tim[i] = !dev_tim_oe_n[i] ? dev_tim_o[i] :
                    (!host_tim_oe_n[i] ? host_tim_o[i] : 1'b1);
  end

  modport dev (input pixel_low_byte, pixel_high_byte, subcarrier_sync_input, tim,
               output dev_tim_o, dev_tim_oe_n);
  modport host (output pixel_low_byte, pixel_high_byte, subcarrier_sync_input,
                output host_tim_o, host_tim_oe_n, input tim);
endinterface
`default_nettype wire

// ### rtl/venc_host_end.sv
`timescale 1ns/100ps
`default_nettype none
module venc_host_end (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  venc_link_if.host        link,
  input  wire logic        mode16,
  input  wire logic [7:0]  px_lo,
  input  wire logic [7:0]  px_hi,
  input  wire logic        px_valid,
  output logic             px_ready,
  input  wire logic        rtc_start,
  input  wire logic [66:0] rtc_word,
  output logic             rtc_busy,
  input  wire logic        sc_reset_req,
  output logic [2:0]       tim_seen
);
  import venc_pkg::*;

  typedef struct packed {
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic        ready;
    logic        tog;
    logic        busy;
    logic [7:0]  cnt;
    logic [67:0] sh;
    logic        sc_o;
    logic [2:0]  tim;
  } host_state_type;

  host_state_type s_ff, nxt_s;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_s = s_ff;
    nxt_s.tog = !s_ff.tog;
    nxt_s.tim = link.tim;
    // wide words change only where the encoder does not load them
    nxt_s.ready = !mode16 || s_ff.tog;
    if (px_valid && s_ff.ready) begin
      nxt_s.lo = px_lo;
      nxt_s.hi = mode16 ? px_hi : 8'h00;
    end
    // serial stream: start bit then 67 bits, each held two clocks
    if (!s_ff.busy) begin
      nxt_s.sc_o = sc_reset_req;
      if (rtc_start) begin
        nxt_s.busy = 1'b1;
        nxt_s.cnt  = 8'h00;
        nxt_s.sh   = {rtc_word, 1'b1};
        nxt_s.sc_o = 1'b1;
      end
    end else begin
      nxt_s.cnt = s_ff.cnt + 8'h01;
      if (s_ff.cnt[0]) begin
        nxt_s.sh   = {1'b0, s_ff.sh[67:1]};
        nxt_s.sc_o = s_ff.sh[1];
      end
      if (s_ff.cnt == HOST_LAST_CNT) begin
        nxt_s.busy = 1'b0;
        nxt_s.sc_o = 1'b0;
      end
    end
  end

  // one register stage for all host state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timing pins left undriven so they rest high in embedded-code slave mode
  assign link.host_tim_o            = 3'h0;
  assign link.host_tim_oe_n         = 3'h7;
  assign link.pixel_low_byte        = s_ff.lo;
  assign link.pixel_high_byte       = s_ff.hi;
  assign link.subcarrier_sync_input = s_ff.sc_o;
  assign px_ready = s_ff.ready;
  assign rtc_busy = s_ff.busy;
  assign tim_seen = s_ff.tim;
endmodule
`default_nettype wire

// ### rtl/venc_device_end.sv
`timescale 1ns/100ps
`default_nettype none
module venc_device_end (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  venc_link_if.dev                    link,
  output logic [7:0]                  y_out,
  output logic [7:0]                  cb_out,
  output logic [7:0]                  cr_out,
  output logic                        pix_valid,
  output venc_pkg::luma_resp_type     luma_resp,
  output logic                        chroma_wide,
  output logic                        sync_out,
  output logic                        eq_pulse,
  output logic                        burst_gate,
  output logic                        setup_on,
  output logic                        colour_on,
  output logic                        sc_phase_reset,
  output logic [31:0]                 sc_freq,
  output logic [2:0]                  field_seq
);
  import venc_pkg::*;

  typedef struct packed {
    logic [31:0]   mode;
    logic [2:0]    tmode;
    logic [23:0]   tim1;
    logic [31:0]   ped;
    logic [31:0]   scfreq;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic [11:0]   hcnt;
    logic [9:0]    line;
    logic          hb;
    logic          vb;
    logic          fb;
    logic [7:0]    b1;
    logic [7:0]    b2;
    logic [7:0]    b3;
    logic          ld16;
    logic [1:0]    phase;
    logic [7:0]    cbh;
    logic [7:0]    crh;
    logic [7:0]    bar_cnt;
    logic [2:0]    bar;
    logic [7:0]    y;
    logic [7:0]    cb;
    logic [7:0]    cr;
    logic          pv;
    logic [2:0]    tim_o;
    logic [2:0]    tim_oe_n;
    logic          sc_d;
    logic          sc_pend;
    logic          sc_rst;
    logic [2:0]    fseq;
    logic          rtc_busy;
    logic [7:0]    rtc_cnt;
    logic [66:0]   rtc_sh;
    logic [21:0]   rtc_freq;
    logic          rtc_new;
    logic [31:0]   sc_freq;
    luma_resp_type resp;
    logic          cwide;
    logic          sync;
    logic          eq;
    logic          burst;
    logic          setup;
  } dev_state_type;

  dev_state_type s_ff, nxt_s;

  logic        pal, sq, wide16, load, code_hit, newline, newfield, vbi, eqline;
  logic        in_active, pass_vbi, sc_rise, rd_hit;
  logic [1:0]  pinf;
  logic [11:0] line_len, half, bs, be;
  logic [9:0]  lines, f2, vbi_n, eq_n, ped_idx;
  logic [7:0]  byte_in, cy, ccb, ccr;
  logic [31:0] rd_val;
  logic [66:0] rtc_next;

  ////////////////////////////////////////////////////////////////////////////
  // geometry chosen by standard and pixel rate
  always_comb begin
    pal      = s_ff.mode[PAL_BIT];
    sq       = s_ff.mode[SQPIX_BIT];
    wide16   = s_ff.mode[WIDE16_BIT];
    pinf     = {s_ff.mode[PINF_HI_BIT], s_ff.mode[PINF_LO_BIT]};
    line_len = pal ? (sq ? PAL_SQ_CLKS : PAL_CLKS) : (sq ? NTSC_SQ_CLKS : NTSC_CLKS);
    half     = {1'b0, line_len[11:1]};
    lines    = pal ? PAL_LINES : NTSC_LINES;
    f2       = pal ? PAL_F2 : NTSC_F2;
    vbi_n    = pal ? PAL_VBI : NTSC_VBI;
    eq_n     = pal ? PAL_EQ : NTSC_EQ;
    vbi      = (s_ff.line <= vbi_n) || (s_ff.line >= f2 && s_ff.line < f2 + vbi_n);
    eqline   = (s_ff.line <= eq_n) || (s_ff.line >= f2 && s_ff.line < f2 + eq_n);
    ped_idx  = (s_ff.line >= PED_F2_FIRST) ? s_ff.line - PED_F2_FIRST + PED_LINES
                                           : s_ff.line - PED_F1_FIRST;
    bs       = {4'h0, s_ff.tim1[15:8]};
    be       = bs + {4'h0, s_ff.tim1[23:16]};
    byte_in  = link.pixel_low_byte;
    load     = !wide16 || s_ff.ld16;
    code_hit = load && s_ff.b3 == CODE_FF && s_ff.b2 == CODE_00 && s_ff.b1 == CODE_00;
    newline  = s_ff.hcnt == 12'h000;
    newfield = newline && (s_ff.line == 10'd1 || s_ff.line == f2);
    sc_rise  = link.subcarrier_sync_input && !s_ff.sc_d;
    in_active = !s_ff.hb;
    // equalization lines stay blanked; other VBI lines carry data if asked
    pass_vbi = s_ff.mode[PVBI_BIT] && !eqline;
    rtc_next = {link.subcarrier_sync_input, s_ff.rtc_sh[66:1]};
  end

  // register decode and read data
  always_comb begin
    rd_hit = 1'b1;
    unique case (paddr)
      MODE_OFS:    rd_val = s_ff.mode;
      TIMING0_OFS: rd_val = {29'h0, s_ff.tmode};
      TIMING1_OFS: rd_val = {8'h0, s_ff.tim1};
      PED_OFS:     rd_val = s_ff.ped;
      SCFREQ_OFS:  rd_val = s_ff.scfreq;
      STATUS_OFS:  rd_val = {4'h0, s_ff.fseq, s_ff.fb, s_ff.vb, s_ff.hb, s_ff.line, s_ff.hcnt};
      RTCFREQ_OFS: rd_val = {10'h0, s_ff.rtc_freq};
      default: begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // pixel path: capture, then colour bars, chroma and blanking
  always_comb begin
    cy  = byte_in;
    ccb = s_ff.cbh;
    ccr = s_ff.crh;
    if (wide16) begin
      ccb = s_ff.phase[0] ? s_ff.cbh : link.pixel_high_byte;
      ccr = s_ff.phase[0] ? link.pixel_high_byte : s_ff.crh;
    end
    if (s_ff.mode[CBAR_BIT]) begin
      {cy, ccb, ccr} = CBAR_TABLE[s_ff.bar];
    end
    if (!s_ff.mode[CHROMA_EN_BIT]) begin
      ccb = ZERO_C;
      ccr = ZERO_C;
    end
    if (s_ff.vb && !pass_vbi) begin
      cy  = BLACK_Y;
      ccb = ZERO_C;
      ccr = ZERO_C;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_s = s_ff;
    nxt_s.sc_rst = 1'b0;
    nxt_s.pv = 1'b0;
    nxt_s.ld16 = !s_ff.ld16;
    // apb: data is prepared in the setup cycle, so no wait states
    nxt_s.pready = psel && !penable;
    if (psel && !penable) begin
      nxt_s.prdata  = rd_val;
      nxt_s.pslverr = !rd_hit;
    end
    if (psel && penable && s_ff.pready && pwrite && rd_hit) begin
      unique case (paddr)
        MODE_OFS:    nxt_s.mode = pwdata;
        TIMING0_OFS: nxt_s.tmode = pwdata[2:0];
        TIMING1_OFS: nxt_s.tim1 = pwdata[23:0];
        PED_OFS:     nxt_s.ped = pwdata;
        SCFREQ_OFS:  nxt_s.scfreq = pwdata;
        default:     nxt_s.mode = s_ff.mode;
      endcase
    end

    // line and field position
    // a shorter line picked mid-line wraps at once instead of running to 4095
    nxt_s.hcnt = (s_ff.hcnt >= line_len - 12'h001) ? 12'h000 : s_ff.hcnt + 12'h001;
    if (s_ff.tmode == TMODE_M0_MASTER) begin
      if (newline) begin
        nxt_s.line = (s_ff.line >= lines) ? 10'd1 : s_ff.line + 10'd1;
      end
      nxt_s.hb = nxt_s.hcnt < line_len - ACTIVE_CLKS;
      nxt_s.vb = vbi;
      nxt_s.fb = s_ff.line >= f2;
    end else if (code_hit && s_ff.tmode == TMODE_M0_SLAVE) begin
      nxt_s.hb = byte_in[4];
      nxt_s.vb = byte_in[5];
      nxt_s.fb = byte_in[6];
      if (byte_in[4]) begin
        nxt_s.hcnt = 12'h000;
        nxt_s.line = (s_ff.fb && !byte_in[6]) ? 10'd1 : s_ff.line + 10'd1;
      end
    end
    if (load) begin
      nxt_s.b1 = byte_in;
      nxt_s.b2 = s_ff.b1;
      nxt_s.b3 = s_ff.b2;
    end

    // pixel capture restarts at every timing code and at each active line start
    if ((s_ff.hb && !nxt_s.hb) || code_hit) begin
      nxt_s.phase   = 2'h0;
      nxt_s.bar     = 3'h0;
      nxt_s.bar_cnt = 8'h00;
    // 00 and ff are reserved for timing codes, so the code preamble is never a pixel
    end else if (in_active && load && !code_hit &&
                 byte_in != CODE_FF && byte_in != CODE_00) begin
      nxt_s.phase = wide16 ? {1'b0, !s_ff.phase[0]} : s_ff.phase + 2'h1;
      if (wide16 || s_ff.phase[0]) begin
        nxt_s.pv = 1'b1;
        nxt_s.y  = cy;
        nxt_s.cb = ccb;
        nxt_s.cr = ccr;
        nxt_s.bar_cnt = (s_ff.bar_cnt == CBAR_PIX - 8'h01) ? 8'h00 : s_ff.bar_cnt + 8'h01;
        if (s_ff.bar_cnt == CBAR_PIX - 8'h01) begin
          nxt_s.bar = s_ff.bar + 3'h1;
        end
      end
      if (wide16) begin
        if (s_ff.phase[0]) nxt_s.crh = link.pixel_high_byte;
        else nxt_s.cbh = link.pixel_high_byte;
      end else if (s_ff.phase == 2'h0) begin
        nxt_s.cbh = byte_in;
      end else if (s_ff.phase == 2'h2) begin
        nxt_s.crh = byte_in;
      end
    end

    // timing pins: enables low only while mastering
    if (s_ff.tmode == TMODE_M0_MASTER) begin
      nxt_s.tim_o    = {nxt_s.fb, nxt_s.vb, nxt_s.hb};
      nxt_s.tim_oe_n = 3'h0;
    end else begin
      nxt_s.tim_o    = 3'h0;
      nxt_s.tim_oe_n = 3'h7;
    end

    // waveform markers for the analog stage
    nxt_s.sync  = s_ff.hcnt < {4'h0, s_ff.tim1[7:0]};
    nxt_s.eq    = eqline && s_ff.hcnt >= half && s_ff.hcnt < half + {4'h0, s_ff.tim1[7:0]};
    nxt_s.burst = s_ff.mode[BURST_EN_BIT] && !eqline &&
                  s_ff.hcnt >= bs && s_ff.hcnt < be;
    if ((s_ff.line >= PED_F1_FIRST && s_ff.line < PED_F1_FIRST + PED_LINES) ||
        (s_ff.line >= PED_F2_FIRST && s_ff.line < PED_F2_FIRST + PED_LINES)) begin
      nxt_s.setup = !pal && s_ff.ped[ped_idx[4:0]];
    end else begin
      nxt_s.setup = !pal && !vbi;
    end
    unique case ({s_ff.mode[LUMA_HI_BIT], s_ff.mode[LUMA_LO_BIT]})
      2'b01:   nxt_s.resp = RESP_NOTCH;
      2'b10:   nxt_s.resp = RESP_EXTENDED;
      default: nxt_s.resp = RESP_LOWPASS;
    endcase
    nxt_s.cwide = pal;

    // subcarrier reset: a new request in the clearing cycle is kept
    nxt_s.sc_d    = link.subcarrier_sync_input;
    nxt_s.sc_pend = (s_ff.sc_pend && !newfield) || (pinf == 2'b01 && sc_rise);
    if (newfield) begin
      nxt_s.sc_rst = s_ff.sc_pend;
      nxt_s.fseq   = s_ff.sc_pend ? 3'h0 : (s_ff.fseq + 3'h1) & (pal ? 3'h7 : 3'h3);
    end

    // real-time stream: start bit, then one sample late in each two-clock bit
    if (!s_ff.rtc_busy) begin
      if (pinf == 2'b11 && sc_rise) begin
        nxt_s.rtc_busy = 1'b1;
        nxt_s.rtc_cnt  = 8'h00;
      end
    end else begin
      nxt_s.rtc_cnt = s_ff.rtc_cnt + 8'h01;
      if (!s_ff.rtc_cnt[0] && s_ff.rtc_cnt != 8'h00) begin
        nxt_s.rtc_sh = rtc_next;
      end
      if (s_ff.rtc_cnt == RTC_LAST_CNT) begin
        nxt_s.rtc_busy = 1'b0;
        nxt_s.rtc_freq = rtc_next[RTC_FREQ_BITS-1:0];
      end
    end
    nxt_s.rtc_new = (s_ff.rtc_new && !newline) ||
                    (s_ff.rtc_busy && s_ff.rtc_cnt == RTC_LAST_CNT);
    // stream mode ignores the programmed frequency register
    if (pinf != 2'b11) begin
      nxt_s.sc_freq = s_ff.scfreq;
    end else if (newline && s_ff.rtc_new) begin
      nxt_s.sc_freq = {s_ff.rtc_freq, 10'h000};
    end
  end

  // one register stage for all device state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_ff        <= '0;
      s_ff.mode   <= MODE_RST;
      s_ff.tmode  <= TIMING0_RST;
      s_ff.tim1   <= TIMING1_RST;
      s_ff.ped    <= PED_RST;
      s_ff.scfreq <= SCFREQ_RST;
      s_ff.line   <= 10'd1;
      s_ff.tim_oe_n <= 3'h7;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign prdata            = s_ff.prdata;
  assign pready            = s_ff.pready;
  assign pslverr           = s_ff.pslverr;
  assign link.dev_tim_o    = s_ff.tim_o;
  assign link.dev_tim_oe_n = s_ff.tim_oe_n;
  assign y_out             = s_ff.y;
  assign cb_out            = s_ff.cb;
  assign cr_out            = s_ff.cr;
  assign pix_valid         = s_ff.pv;
  assign luma_resp         = s_ff.resp;
  assign chroma_wide       = s_ff.cwide;
  assign sync_out          = s_ff.sync;
  assign eq_pulse          = s_ff.eq;
  assign burst_gate        = s_ff.burst;
  assign setup_on          = s_ff.setup;
  assign colour_on         = s_ff.mode[CHROMA_EN_BIT];
  assign sc_phase_reset    = s_ff.sc_rst;
  assign sc_freq           = s_ff.sc_freq;
  assign field_seq         = s_ff.fseq;
endmodule
`default_nettype wire

// ### bench/venc_link_properties.sv
`timescale 1ns/100ps
`default_nettype none
module venc_link_properties (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] pixel_low_byte,
  input wire logic [7:0] pixel_high_byte,
  input wire logic       subcarrier_sync_input,
  input wire logic [2:0] dev_tim_o,
  input wire logic [2:0] dev_tim_oe_n,
  input wire logic [2:0] host_tim_o,
  input wire logic [2:0] host_tim_oe_n,
  input wire logic [2:0] tim
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // timing pins turn round as one group, never a mix of driven and floating
  property p_oe_group; dev_tim_oe_n == 3'b000 || dev_tim_oe_n == 3'b111; endproperty
  a_oe_group: assert property (p_oe_group) else $error("timing enables split");
  property p_float; dev_tim_oe_n == 3'b111 |-> tim == 3'b111; endproperty
  a_float: assert property (p_float) else $error("idle timing pin not high");
  property p_drive; dev_tim_oe_n == 3'b000 |-> tim == dev_tim_o; endproperty
  a_drive: assert property (p_drive) else $error("master pins not on wire");
  property p_host_off; host_tim_oe_n == 3'b111; endproperty
  a_host_off: assert property (p_host_off) else $error("host drives timing pin");
  // h pulses last far longer than eight clocks, so a flicker means a broken counter
  property p_h_steady;
    dev_tim_oe_n == 3'b000 && $past(dev_tim_oe_n) == 3'b000 && $changed(dev_tim_o[0])
      |=> ($stable(dev_tim_o[0]) || dev_tim_oe_n != 3'b000) [*8];
  endproperty
  a_h_steady: assert property (p_h_steady) else $error("h pin flickers");
  // every level of the shared input lasts at least two clocks
  property p_bit_hold; $changed(subcarrier_sync_input) |=> $stable(subcarrier_sync_input);
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("stream bit too short");
  property p_dev_rst; $rose(rst_n) |-> dev_tim_oe_n == 3'b111; endproperty
  a_dev_rst: assert property (p_dev_rst) else $error("pins driven after reset");
  property p_host_rst;
    $rose(rst_n) |-> subcarrier_sync_input == 1'b0 && pixel_low_byte == 8'h00;
  endproperty
  a_host_rst: assert property (p_host_rst) else $error("host pins not cleared");
  c_master: cover property (dev_tim_oe_n == 3'b000 ##1 $changed(dev_tim_o[0]));
  c_stream: cover property ($rose(subcarrier_sync_input));
  c_code: cover property (pixel_low_byte == 8'hff ##1 pixel_low_byte == 8'h00
                          ##1 pixel_low_byte == 8'h00);
endmodule
`default_nettype wire

// ### bench/video_encoder_input_timing_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module video_encoder_input_timing_tb_top;
  import venc_pkg::*;
  logic          mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic          pready, pslverr, pix_valid, px_ready, rtc_busy, chroma_wide, colour_on;
  logic          rtc_start = 0, px_valid = 0, sync_out;
  logic [11:0]   paddr = '0;
  logic [31:0]   pwdata = '0, prdata, sc_freq;
  logic [7:0]    y_out, cb_out, px_lo = '0;
  logic [66:0]   rtc_word = '0;
  luma_resp_type luma_resp;
  logic [32:0]   bus_q[$];
  logic [15:0]   pix_q[$];
  int            bad_count = 0, compares = 0;
  venc_link_if link (.mclk(mclk));
  venc_host_end u_venc_host_end (.mclk(mclk), .rst_n(rst_n), .link(link), .mode16(1'b0),
    .px_lo(px_lo), .px_hi(8'h80), .px_valid(px_valid), .px_ready(px_ready),
    .rtc_start(rtc_start), .rtc_word(rtc_word), .rtc_busy(rtc_busy),
    .sc_reset_req(1'b0), .tim_seen());
  venc_device_end u_venc_device_end (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link), .y_out(y_out), .cb_out(cb_out),
    .cr_out(), .pix_valid(pix_valid), .luma_resp(luma_resp), .chroma_wide(chroma_wide),
    .sync_out(sync_out), .eq_pulse(), .burst_gate(), .setup_on(), .colour_on(colour_on),
    .sc_phase_reset(), .sc_freq(sc_freq), .field_seq());
  venc_link_properties u_venc_link_properties (.mclk(mclk), .rst_n(rst_n),
    .pixel_low_byte(link.pixel_low_byte), .pixel_high_byte(link.pixel_high_byte),
    .subcarrier_sync_input(link.subcarrier_sync_input), .dev_tim_o(link.dev_tim_o),
    .dev_tim_oe_n(link.dev_tim_oe_n), .host_tim_o(link.host_tim_o),
    .host_tim_oe_n(link.host_tim_oe_n), .tim(link.tim));
  always #10 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task give_verdict;
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one apb transfer; an idle cycle after it keeps psel from being set twice at one edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task rd(input logic [11:0] a, input logic [32:0] exp);
    bus_q.push_back(exp);
    apb(0, a, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // results are matched against the oldest note as they appear
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("apb", {pslverr, prdata}, bus_q.pop_front());
    // a pixel with no note behind it is a mismatch too
    if (pix_valid === 1'b1) begin
      if (pix_q.size() > 0)
        check("pixel", {y_out, cb_out}, pix_q.pop_front());
      else
        check("pixel_extra", 1'b1, 1'b0);
    end
  end
  // whole run is well under this span
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    give_verdict;
  end
  initial begin
    logic [31:0] m;
    logic [66:0] w;
    logic [7:0]  b [12];
    int          i;
    time         t;
    void'($urandom(32'h134e));
    repeat (8) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    rd(MODE_OFS, {1'b0, MODE_RST});
    rd(TIMING1_OFS, {9'h0, TIMING1_RST});
    rd(12'h01c, {1'b1, 32'h0});
    // every luma code, with the standard and colour bit picked at random
    for (int k = 0; k < 4; k++) begin
      m = ($urandom & 32'h34) | 32'(k);
      apb(1, MODE_OFS, m);
      repeat (2) @(posedge mclk);
      check("luma", luma_resp,
            k == 1 ? RESP_NOTCH : (k == 2 ? RESP_EXTENDED : RESP_LOWPASS));
      check("chroma", chroma_wide, m[PAL_BIT]);
      check("colour", colour_on, m[CHROMA_EN_BIT]);
      rd(MODE_OFS, {1'b0, m});
    end
    apb(1, TIMING0_OFS, {29'h0, TMODE_M0_MASTER});
    repeat (2) @(posedge mclk);
    check("oe_master", link.dev_tim_oe_n, 3'b000);
    // stream runs while master timing keeps lines turning over
    apb(1, MODE_OFS, 32'hf0);
    apb(1, SCFREQ_OFS, 32'h0);
    w = 67'({$urandom, $urandom, $urandom});
    rtc_word <= w;
    rtc_start <= 1;
    @(posedge mclk);
    rtc_start <= 0;
    repeat (2) @(posedge mclk);
    for (i = 0; i < 300 && rtc_busy !== 1'b0; i++) @(posedge mclk);
    rd(RTCFREQ_OFS, {11'h0, w[21:0]});
    for (i = 0; i < 4000 && sc_freq !== {w[21:0], 10'h0}; i++) @(posedge mclk);
    check("sc_freq", sc_freq, {w[21:0], 10'h0});
    apb(1, TIMING0_OFS, {29'h0, TMODE_M0_SLAVE});
    repeat (2) @(posedge mclk);
    check("oe_slave", link.dev_tim_oe_n, 3'b111);
    // start code, two pixels, end code; bytes avoid the code values
    apb(1, MODE_OFS, MODE_RST);
    b = '{8'hff, 8'h00, 8'h00, 8'h80, 8'h0, 8'h0, 8'h0, 8'h0, 8'hff, 8'h00, 8'h00, 8'h90};
    for (i = 4; i < 8; i++) b[i] = 8'($urandom_range(254, 1));
    pix_q.push_back({b[5], b[4]});
    pix_q.push_back({b[7], b[4]});
    for (i = 0; i < 12; i++) begin
      px_lo <= b[i];
      px_valid <= 1;
      do @(posedge mclk); while (px_ready !== 1'b1);
    end
    px_valid <= 0;
    repeat (10) @(posedge mclk);
    check("pix_left", pix_q.size(), 0);
    // square pixel: one whole line timed between two sync rises, standard at random
    m = 32'h430 | ($urandom & 32'h4);
    apb(1'b1, MODE_OFS, m);
    @(posedge sync_out);
    t = $time;
    @(posedge sync_out);
    check("line_len", ($time - t) / 20, m[PAL_BIT] ? PAL_SQ_CLKS : NTSC_SQ_CLKS);
    give_verdict;
  end
endmodule
`default_nettype wire
